/* logic/dcpwm_map.vh */
// Register offsets, field positions, reset values and timing counts of the motor PWM block
`ifndef DCPWM_MAP_VH
`define DCPWM_MAP_VH
// Offsets are register indices; the bus address is four times the index
`define DCPWM_IDX_CH0_PIN_STATUS   8'h02
`define DCPWM_IDX_CH0_SEQ_COUNTER  8'h03
`define DCPWM_IDX_CH1_PIN_STATUS   8'h0A
`define DCPWM_IDX_CH1_SEQ_COUNTER  8'h0B
`define DCPWM_IDX_CH0_CTRL         8'h10
`define DCPWM_IDX_CH0_DUTY         8'h11
`define DCPWM_IDX_CH0_PERIOD       8'h12
`define DCPWM_IDX_CH1_CTRL         8'h18
`define DCPWM_IDX_CH1_DUTY         8'h19
`define DCPWM_IDX_CH1_PERIOD       8'h1A
`define DCPWM_IDX_CFG              8'h20
// Pin status fields
`define DCPWM_STS_RUNNING          0
`define DCPWM_STS_OUT_A            1
`define DCPWM_STS_OUT_B            2
`define DCPWM_STS_INPUT            3
`define DCPWM_STS_SW_ECHO          5
// Control fields
`define DCPWM_CTL_RUN              0
`define DCPWM_CTL_FUNC_LO          1
`define DCPWM_CTL_FUNC_HI          2
`define DCPWM_CTL_ISO              3
// Input function codes
`define DCPWM_FUNC_INPUT           2'h0
`define DCPWM_FUNC_HW_GATE         2'h1
`define DCPWM_FUNC_EXT_STOP        2'h2
// Config fields
`define DCPWM_CFG_TWO_CH           0
`define DCPWM_CFG_FILT_LO          8
`define DCPWM_CFG_FILT_HI          15
`define DCPWM_CFG_ONDLY_LO         16
`define DCPWM_CFG_ONDLY_HI         31
// Reset values
`define DCPWM_RST_CFG              32'h0000_0001
`define DCPWM_RST_PERIOD_US        32'h0000_03E8
// Duty full scale and period limits
`define DCPWM_DUTY_FULL            16'h6C00
`define DCPWM_PERIOD_MIN_US        32'h0000_0064
`define DCPWM_PERIOD_MAX_US        32'h0510_FF40
// Timing: cycles per microsecond at 100 MHz
`define DCPWM_CLK_MHZ              100
`define DCPWM_CYC_PER_US           (`DCPWM_CLK_MHZ)
`endif

/* logic/dcpwm_channel.v */
// One motor PWM channel: input filter, start/stop control, on-delay and pulse generation
`timescale 1ns/1ps
`include "dcpwm_map.vh"
module dcpwm_channel #(
   parameter CW = 40
) (
   // Clock and reset
   input  wire        hclk,
   input  wire        hresetn,
   // Configuration and digital input
   input  wire        software_run_request,
   input  wire [1:0]  input_function_select,
   input  wire        iso_mode,
   input  wire [7:0]  filt_us,
   input  wire [15:0] ondly_us,
   input  wire [15:0] duty_raw,
   input  wire [31:0] period_us,
   input  wire        din,
   // Status and outputs
   output reg         sequence_running_flag,
   output reg         input_level_flag,
   output reg         out_a,
   output reg         out_b,
   output reg         out_oe
);
   localparam [2:0] S_IDLE = 3'b001;
   localparam [2:0] S_DLY  = 3'b010;
   localparam [2:0] S_RUN  = 3'b100;
   reg [2:0]    state_r;
   reg          filt_r;
   reg [31:0]   fcnt_r;
   reg          sw_q_r;
   reg          fq_r;
   reg [CW-1:0] cnt_r;
   reg [CW-1:0] per_cyc_r;
   reg [CW-1:0] hi_cyc_r;
   reg          dir_back_r;
   wire         hw_gate = (input_function_select == `DCPWM_FUNC_HW_GATE) && !iso_mode;
   wire         sw_rise = software_run_request && !sw_q_r;
   wire         sw_fall = !software_run_request && sw_q_r;
   wire         f_rise  = filt_r && !fq_r;
   wire         f_fall  = !filt_r && fq_r;
   wire [31:0]  filt_cyc = {24'h000000, filt_us} * `DCPWM_CYC_PER_US;
   // Clamped magnitude and direction of the duty value
   wire         neg = duty_raw[15];
   wire [15:0]  mag0 = neg ? (~duty_raw + 16'h0001) : duty_raw;
   wire [15:0]  mag = (mag0 > `DCPWM_DUTY_FULL) ? `DCPWM_DUTY_FULL : mag0;
   wire [31:0]  per_cl = (period_us < `DCPWM_PERIOD_MIN_US) ? `DCPWM_PERIOD_MIN_US :
                         (period_us > `DCPWM_PERIOD_MAX_US) ? `DCPWM_PERIOD_MAX_US : period_us;
   wire [CW-1:0] per_nxt = {{(CW-32){1'b0}}, per_cl} * `DCPWM_CYC_PER_US;
   wire [CW+15:0] prod = {16'h0000, per_nxt} * {{CW{1'b0}}, mag};
   // Quotient never exceeds the period, so its upper bits are always zero
   wire [CW+15:0] quo = prod / {{CW{1'b0}}, `DCPWM_DUTY_FULL};
   wire [CW-1:0] hi_nxt = quo[CW-1:0];
   wire [CW-1:0] dly_cyc = {{(CW-16){1'b0}}, ondly_us} * `DCPWM_CYC_PER_US;
   wire         start = hw_gate ? (software_run_request && f_rise)
                                : sw_rise;
   wire         stop  = !software_run_request
                        || (hw_gate && f_fall)
                        || (input_function_select == `DCPWM_FUNC_EXT_STOP && f_rise);
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         filt_r                <= 1'b0;
         fcnt_r                <= 32'h0000_0000;
         sw_q_r                <= 1'b0;
         fq_r                  <= 1'b0;
         input_level_flag      <= 1'b0;
         state_r               <= S_IDLE;
         cnt_r                 <= {CW{1'b0}};
         per_cyc_r             <= {CW{1'b0}};
         hi_cyc_r              <= {CW{1'b0}};
         dir_back_r            <= 1'b0;
         sequence_running_flag <= 1'b0;
         out_a                 <= 1'b0;
         out_b                 <= 1'b0;
         out_oe                <= 1'b0;
      end else begin
         input_level_flag <= din;
         sw_q_r           <= software_run_request;
         fq_r             <= filt_r;
         // Input must stay stable for the full filter time before it is taken
         if (din == filt_r) begin
            fcnt_r <= 32'h0000_0000;
         end else if (fcnt_r >= filt_cyc) begin
            filt_r <= din;
            fcnt_r <= 32'h0000_0000;
         end else begin
            fcnt_r <= fcnt_r + 32'h0000_0001;
         end
         case (state_r)
            S_IDLE: begin
               out_oe <= 1'b0;
               out_a  <= 1'b0;
               out_b  <= 1'b0;
               if (start) begin
                  state_r               <= S_DLY;
                  sequence_running_flag <= 1'b1;
                  cnt_r                 <= {CW{1'b0}};
                  out_oe                <= 1'b1;
               end
            end
            S_DLY: begin
               if (stop) begin
                  state_r <= S_IDLE;
                  sequence_running_flag <= 1'b0;
                  out_oe  <= 1'b0;
               end else if (cnt_r >= dly_cyc) begin
                  state_r <= S_RUN;
                  cnt_r   <= {CW{1'b0}};
               end else begin
                  cnt_r <= cnt_r + {{(CW-1){1'b0}}, 1'b1};
               end
            end
            S_RUN: begin
               if (stop) begin
                  state_r <= S_IDLE;
                  sequence_running_flag <= 1'b0;
                  out_oe  <= 1'b0;
                  out_a   <= 1'b0;
                  out_b   <= 1'b0;
               end else begin
                  // New duty and period are latched only at the start of a period
                  if (cnt_r == {CW{1'b0}}) begin
                     per_cyc_r  <= per_nxt;
                     hi_cyc_r   <= hi_nxt;
                     dir_back_r <= neg;
                     out_a      <= (hi_nxt != {CW{1'b0}}) && !neg;
                     out_b      <= (hi_nxt != {CW{1'b0}}) && neg;
                     cnt_r      <= {{(CW-1){1'b0}}, 1'b1};
                  end else begin
                     if (cnt_r >= hi_cyc_r) begin
                        out_a <= 1'b0;
                        out_b <= 1'b0;
                     end else begin
                        out_a <= !dir_back_r;
                        out_b <= dir_back_r;
                     end
                     cnt_r <= (cnt_r + {{(CW-1){1'b0}}, 1'b1} >= per_cyc_r) ? {CW{1'b0}}
                              : cnt_r + {{(CW-1){1'b0}}, 1'b1};
                  end
               end
            end
            default: state_r <= S_IDLE;
         endcase
      end
   end
endmodule

/* logic/dcpwm_top.v */
// AHB-Lite register slave and two DC motor PWM channels with pin status feedback
//
// Contract
// - Channel B output level is readable in pin status bit 2.
// - Digital input level is readable in pin status bit 3.
// - Unassigned feedback bits and bytes always read zero.
// - Channel 1 feedback exists only in two-channel configuration.
// - Hardware gate input is noise filtered by configured delay before acting.
// - Forward high phase drives A high, B low.
// - Backward high phase drives A low, B high.
// - Low phase drives both outputs low.
// - Hardware gate mode starts on input rise, stops on input fall.
// - External stop mode starts on enable rise; stops on input rise or enable fall.
// - Plain input mode uses only software enable edges.
// - Continuous pulses with duty ratio from signed duty over period.
// - Pulses begin only after on-delay expires.
// - Software enable is echoed in a readable status bit.
// - First gate rise starts; further rises ignored while running.
// - Hardware gate unavailable in isochronous mode.
// - Filtered start begins on-delay and sets the running flag.
// - Sequence runs continuously while software enable stays set and no input-caused stop occurs.
// - Clearing software enable cancels immediately, mid-period.
// - Input-caused stops behave exactly like software cancellation.
// - Low 16 duty bits, sign is direction, clamp at 27648 full scale.
// - New duty applies only at next output rising edge.
// - Period limited to 100 us .. 85,000,000 us, applied at next rising edge.
`timescale 1ns/1ps
`include "dcpwm_map.vh"
module dcpwm_top #(
   parameter CW = 40
) (
   // Clock and reset
   input  wire        hclk,
   input  wire        hresetn,
   // AHB-Lite slave
   input  wire        hsel,
   input  wire [31:0] haddr,
   input  wire [1:0]  htrans,
   input  wire        hwrite,
   input  wire [2:0]  hsize,
   input  wire        hready,
   input  wire [31:0] hwdata,
   output reg  [31:0] hrdata,
   output reg         hreadyout,
   output reg         hresp,
   // Digital inputs
   input  wire        din0,
   input  wire        din1,
   // Bridge outputs with enables
   output reg         bridge_out_a0,
   output reg         bridge_out_b0,
   output reg         bridge_oe0,
   output reg         bridge_out_a1,
   output reg         bridge_out_b1,
   output reg         bridge_oe1
);
   reg [3:0]  ctrl0_r;
   reg [3:0]  ctrl1_r;
   reg [15:0] duty0_r;
   reg [15:0] duty1_r;
   reg [31:0] per0_r;
   reg [31:0] per1_r;
   reg [31:0] cfg_r;
   reg        wr_pend_r;
   reg [7:0]  wr_idx_r;
   wire       run0;
   wire       run1;
   wire       in0;
   wire       in1;
   wire       a0;
   wire       b0;
   wire       oe0;
   wire       a1;
   wire       b1;
   wire       oe1;
   wire       two_ch = cfg_r[`DCPWM_CFG_TWO_CH];
   wire       acc    = hsel && hready && htrans[1];
   wire [7:0] idx    = haddr[9:2];
   dcpwm_channel #(.CW(CW)) u_ch0 (
      .hclk                  (hclk),
      .hresetn               (hresetn),
      .software_run_request  (ctrl0_r[`DCPWM_CTL_RUN]),
      .input_function_select (ctrl0_r[`DCPWM_CTL_FUNC_HI:`DCPWM_CTL_FUNC_LO]),
      .iso_mode              (ctrl0_r[`DCPWM_CTL_ISO]),
      .filt_us               (cfg_r[`DCPWM_CFG_FILT_HI:`DCPWM_CFG_FILT_LO]),
      .ondly_us              (cfg_r[`DCPWM_CFG_ONDLY_HI:`DCPWM_CFG_ONDLY_LO]),
      .duty_raw              (duty0_r),
      .period_us             (per0_r),
      .din                   (din0),
      .sequence_running_flag (run0),
      .input_level_flag      (in0),
      .out_a                 (a0),
      .out_b                 (b0),
      .out_oe                (oe0)
   );
   dcpwm_channel #(.CW(CW)) u_ch1 (
      .hclk                  (hclk),
      .hresetn               (hresetn),
      .software_run_request  (ctrl1_r[`DCPWM_CTL_RUN] && two_ch),
      .input_function_select (ctrl1_r[`DCPWM_CTL_FUNC_HI:`DCPWM_CTL_FUNC_LO]),
      .iso_mode              (ctrl1_r[`DCPWM_CTL_ISO]),
      .filt_us               (cfg_r[`DCPWM_CFG_FILT_HI:`DCPWM_CFG_FILT_LO]),
      .ondly_us              (cfg_r[`DCPWM_CFG_ONDLY_HI:`DCPWM_CFG_ONDLY_LO]),
      .duty_raw              (duty1_r),
      .period_us             (per1_r),
      .din                   (din1),
      .sequence_running_flag (run1),
      .input_level_flag      (in1),
      .out_a                 (a1),
      .out_b                 (b1),
      .out_oe                (oe1)
   );
   // Pin status bytes; everything unassigned reads zero
   wire [31:0] sts0 = {26'h0, ctrl0_r[`DCPWM_CTL_RUN], 1'b0, in0, bridge_out_b0, bridge_out_a0, run0};
   wire [31:0] sts1 = two_ch ? {26'h0, ctrl1_r[`DCPWM_CTL_RUN], 1'b0, in1, bridge_out_b1, bridge_out_a1, run1}
                             : 32'h0000_0000;
   reg  [31:0] rd_nxt;
   always @* begin
      case (idx)
         `DCPWM_IDX_CH0_PIN_STATUS:  rd_nxt = sts0;
         `DCPWM_IDX_CH1_PIN_STATUS:  rd_nxt = sts1;
         `DCPWM_IDX_CH0_CTRL:        rd_nxt = {28'h0, ctrl0_r};
         `DCPWM_IDX_CH0_DUTY:        rd_nxt = {16'h0, duty0_r};
         `DCPWM_IDX_CH0_PERIOD:      rd_nxt = per0_r;
         `DCPWM_IDX_CH1_CTRL:        rd_nxt = {28'h0, ctrl1_r};
         `DCPWM_IDX_CH1_DUTY:        rd_nxt = {16'h0, duty1_r};
         `DCPWM_IDX_CH1_PERIOD:      rd_nxt = per1_r;
         `DCPWM_IDX_CFG:             rd_nxt = cfg_r;
         default:                    rd_nxt = 32'h0000_0000;
      endcase
   end
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata        <= 32'h0000_0000;
         hreadyout     <= 1'b1;
         hresp         <= 1'b0;
         wr_pend_r     <= 1'b0;
         wr_idx_r      <= 8'h00;
         ctrl0_r       <= 4'h0;
         ctrl1_r       <= 4'h0;
         duty0_r       <= 16'h0000;
         duty1_r       <= 16'h0000;
         per0_r        <= `DCPWM_RST_PERIOD_US;
         per1_r        <= `DCPWM_RST_PERIOD_US;
         cfg_r         <= `DCPWM_RST_CFG;
         bridge_out_a0 <= 1'b0;
         bridge_out_b0 <= 1'b0;
         bridge_oe0    <= 1'b0;
         bridge_out_a1 <= 1'b0;
         bridge_out_b1 <= 1'b0;
         bridge_oe1    <= 1'b0;
      end else begin
         wr_pend_r <= acc && hwrite;
         if (acc) begin
            wr_idx_r <= idx;
         end
         if (acc && !hwrite) begin
            hrdata <= rd_nxt;
         end
         if (wr_pend_r) begin
            case (wr_idx_r)
               `DCPWM_IDX_CH0_CTRL:   ctrl0_r <= hwdata[3:0];
               `DCPWM_IDX_CH0_DUTY:   duty0_r <= hwdata[15:0];
               `DCPWM_IDX_CH0_PERIOD: per0_r  <= hwdata;
               `DCPWM_IDX_CH1_CTRL:   ctrl1_r <= hwdata[3:0];
               `DCPWM_IDX_CH1_DUTY:   duty1_r <= hwdata[15:0];
               `DCPWM_IDX_CH1_PERIOD: per1_r  <= hwdata;
               `DCPWM_IDX_CFG:        cfg_r   <= hwdata;
               default: ;
            endcase
         end
         bridge_out_a0 <= a0;
         bridge_out_b0 <= b0;
         bridge_oe0    <= oe0;
         // Paralleled outputs must never fight each other
         bridge_out_a1 <= two_ch ? a1 : a0;
         bridge_out_b1 <= two_ch ? b1 : b0;
         bridge_oe1    <= two_ch ? oe1 : oe0;
      end
   end
endmodule

/* verif/dcpwm_top_checker.sv */
// Concurrent checks on the ports of the motor PWM top
`timescale 1ns/1ps
module dcpwm_top_checker #(
   parameter CW = 40
) (
   // Clock and reset
   input logic        hclk,
   input logic        hresetn,
   // Bus
   input logic        hsel,
   input logic [31:0] haddr,
   input logic [1:0]  htrans,
   input logic        hwrite,
   input logic [2:0]  hsize,
   input logic        hready,
   input logic [31:0] hwdata,
   input logic [31:0] hrdata,
   input logic        hreadyout,
   input logic        hresp,
   // Pins
   input logic        din0,
   input logic        din1,
   input logic        bridge_out_a0,
   input logic        bridge_out_b0,
   input logic        bridge_oe0,
   input logic        bridge_out_a1,
   input logic        bridge_out_b1,
   input logic        bridge_oe1
);
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   wire       rd_take = hsel && hready && htrans[1] && !hwrite;
   wire [1:0] pins0   = {bridge_out_b0, bridge_out_a0};

   chk_bus_okay: assert property (hreadyout && !hresp) else $error("bus wait or error response");
   chk_unmapped_zero: assert property (rd_take && haddr > 32'h0000_0080 |=> hrdata == 32'h0)
      else $error("unmapped read not zero");
   chk_seq_zero: assert property (rd_take && haddr == 32'h0000_000C |=> hrdata == 32'h0)
      else $error("sequence count read not zero");
   chk_sts_reserved: assert property (rd_take && haddr == 32'h0000_0008 |=> hrdata[31:6] == 0 && !hrdata[4])
      else $error("reserved status bits set");
   chk_sts_pins: assert property (rd_take && haddr == 32'h0000_0008 |=> hrdata[2:1] == $past(pins0))
      else $error("status pin bits differ from pins");
   chk_pair_excl0: assert property (!(bridge_out_a0 && bridge_out_b0)) else $error("both ch0 outputs high");
   chk_pair_excl1: assert property (!(bridge_out_a1 && bridge_out_b1)) else $error("both ch1 outputs high");
   chk_float_quiet0: assert property (bridge_out_a0 || bridge_out_b0 |-> bridge_oe0)
      else $error("ch0 high while floated");
   chk_float_quiet1: assert property (bridge_out_a1 || bridge_out_b1 |-> bridge_oe1)
      else $error("ch1 high while floated");
   chk_ondly_low: assert property ($rose(bridge_oe0) |-> !bridge_out_a0 && !bridge_out_b0)
      else $error("pulse at sequence start");

   cov_fwd: cover property (bridge_oe0 && bridge_out_a0);
   cov_bwd: cover property (bridge_oe0 && bridge_out_b0);
   cov_stop: cover property ($fell(bridge_oe0));
endmodule

bind dcpwm_top dcpwm_top_checker #(.CW(CW)) u_chk (
   .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
   .hsize(hsize), .hready(hready), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
   .hresp(hresp), .din0(din0), .din1(din1), .bridge_out_a0(bridge_out_a0),
   .bridge_out_b0(bridge_out_b0), .bridge_oe0(bridge_oe0), .bridge_out_a1(bridge_out_a1),
   .bridge_out_b1(bridge_out_b1), .bridge_oe1(bridge_oe1)
);

/* verif/dcpwm_motor_load.sv */
// Motor winding across one bridge pair: wire levels and drive tallies
`timescale 1ns/1ps
module dcpwm_motor_load (
   // Clock and tally clear
   input  logic        hclk,
   input  logic        clr,
   // Bridge pins
   input  logic        a,
   input  logic        b,
   input  logic        oe,
   // Wire levels and tallies
   output wire         wire_a,
   output wire         wire_b,
   output logic [31:0] fwd_cnt,
   output logic [31:0] bwd_cnt
);
   // Winding has no pull, so a floated terminal really floats
   assign wire_a = oe ? a : 1'bz;
   assign wire_b = oe ? b : 1'bz;
   always @(posedge hclk) begin
      if (clr) begin
         fwd_cnt <= 32'h0;
         bwd_cnt <= 32'h0;
      end else begin
         fwd_cnt <= fwd_cnt + {31'h0, wire_a === 1'b1 && wire_b === 1'b0};
         bwd_cnt <= bwd_cnt + {31'h0, wire_a === 1'b0 && wire_b === 1'b1};
      end
   end
endmodule

/* verif/dc_motor_hbridge_pwm_channel_tb.sv */
// Self-checking bench for the motor PWM top, motor load on channel 0
`timescale 1ns/1ps
`include "dcpwm_map.vh"
module dc_motor_hbridge_pwm_channel_tb;
   logic        hclk;
   logic        hresetn;
   logic        hsel;
   logic [31:0] haddr;
   logic [1:0]  htrans;
   logic        hwrite;
   logic [2:0]  hsize;
   logic [31:0] hwdata;
   logic        din0;
   logic        din1;
   logic        clr;
   logic [31:0] st;
   wire  [31:0] hrdata;
   wire         hreadyout;
   wire         hresp;
   wire         a0, b0, oe0, a1, b1, oe1;
   wire  [31:0] fwd_cnt;
   wire  [31:0] bwd_cnt;
   int          n_mismatch = 0;
   int          cmp_count  = 0;
   int          cyc        = 0;

   dcpwm_top #(.CW(40)) dut (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(hresp), .din0(din0), .din1(din1), .bridge_out_a0(a0), .bridge_out_b0(b0),
      .bridge_oe0(oe0), .bridge_out_a1(a1), .bridge_out_b1(b1), .bridge_oe1(oe1)
   );
   dcpwm_motor_load load0 (
      .hclk(hclk), .clr(clr), .a(a0), .b(b0), .oe(oe0),
      .wire_a(), .wire_b(), .fwd_cnt(fwd_cnt), .bwd_cnt(bwd_cnt)
   );

   initial begin
      hclk = 1'b0;
      forever #5 hclk = ~hclk;
   end
   always @(posedge hclk) begin
      cyc <= cyc + 1;
      if (cyc == 100000) begin
         n_mismatch = n_mismatch + 1;
         end_sim();
      end
   end

   task automatic end_sim();
      $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge hclk);
   endtask
   // Single word transfer; read data lands in st
   task automatic bus(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
      hsel   <= 1'b1;
      haddr  <= {22'h0, idx, 2'b00};
      htrans <= 2'h2;
      hwrite <= wr;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      htrans <= 2'h0;
      hwdata <= wd;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      st = hrdata;
   endtask
   task automatic status();
      bus(1'b0, `DCPWM_IDX_CH0_PIN_STATUS, 32'h0);
   endtask
   task automatic ctrl(input logic [31:0] d);
      bus(1'b1, `DCPWM_IDX_CH0_CTRL, d);
   endtask
   task automatic tally();
      clr <= 1'b1;
      tick(1);
      clr <= 1'b0;
      tick(10000);
   endtask

   task automatic t_reset();
      status();
      check(st, 32'h0);
      bus(1'b0, `DCPWM_IDX_CH0_SEQ_COUNTER, 32'h0);
      check(st, 32'h0);
      bus(1'b0, 8'h3F, 32'h0);
      check(st, 32'h0);
      check({31'h0, oe0}, 32'h0);
      din1 <= 1'b1;
      tick(2);
      bus(1'b0, `DCPWM_IDX_CH1_PIN_STATUS, 32'h0);
      check(st, 32'h8);
      din1 <= 1'b0;
   endtask
   task automatic t_fwd();
      bus(1'b1, `DCPWM_IDX_CH0_DUTY, 32'h0000_3600);
      ctrl(32'h1);
      tick(150);
      status();
      check(st, 32'h21);
      check({29'h0, oe0, a0, b0}, 32'h4);
      din0 <= 1'b1;
      for (int i = 0; i < 1000 && a0 !== 1'b1; i++) @(posedge hclk);
      check({30'h0, a0, b0}, 32'h2);
      tally();
      check({31'h0, fwd_cnt >= 4995 && fwd_cnt <= 5005}, 32'h1);
      status();
      check(st & 32'h9, 32'h9);
      din0 <= 1'b0;
      for (int i = 0; i < 11000 && a0 !== 1'b1; i++) @(posedge hclk);
      ctrl(32'h0);
      tick(3);
      check({31'h0, oe0}, 32'h0);
      status();
      check(st & 32'h21, 32'h0);
   endtask
   task automatic t_back();
      bus(1'b1, `DCPWM_IDX_CH0_DUTY, 32'h1234_8000);
      ctrl(32'h1);
      tick(700);
      tally();
      check(fwd_cnt, 32'h0);
      check({31'h0, bwd_cnt >= 9990}, 32'h1);
      status();
      check(st & 32'h6, 32'h4);
      ctrl(32'h0);
      tick(3);
   endtask
   task automatic t_gate();
      // Isochronous: gate unavailable, run request alone starts and the input is ignored
      ctrl(32'hB);
      din0 <= 1'b1;
      tick(300);
      din0 <= 1'b0;
      tick(300);
      check({31'h0, oe0}, 32'h1);
      ctrl(32'h0);
      tick(3);
      ctrl(32'h3);
      tick(300);
      din0 <= 1'b1;
      tick(50);
      din0 <= 1'b0;
      tick(300);
      check({31'h0, oe0}, 32'h0);
      din0 <= 1'b1;
      tick(300);
      status();
      check(st & 32'h21, 32'h21);
      din0 <= 1'b0;
      for (int i = 0; i < 300 && oe0 !== 1'b0; i++) @(posedge hclk);
      status();
      check({st[0], oe0}, 2'h0);
      ctrl(32'h0);
   endtask
   task automatic t_ext();
      ctrl(32'h4);
      ctrl(32'h5);
      tick(150);
      status();
      check(st & 32'h1, 32'h1);
      din0 <= 1'b1;
      tick(300);
      check({31'h0, oe0}, 32'h0);
      din0 <= 1'b0;
      tick(300);
      status();
      check(st & 32'h1, 32'h0);
      ctrl(32'h0);
   endtask
   task automatic t_par();
      bus(1'b1, `DCPWM_IDX_CFG, 32'h0005_0100);
      bus(1'b0, `DCPWM_IDX_CH1_PIN_STATUS, 32'h0);
      check(st, 32'h0);
      bus(1'b1, `DCPWM_IDX_CH0_DUTY, 32'h0000_6C00);
      ctrl(32'h1);
      tick(800);
      check({29'h0, oe0, a0, b0}, 32'h6);
      check({29'h0, oe1, a1, b1}, 32'h6);
      ctrl(32'h0);
   endtask

   initial begin
      hresetn = 1'b0;
      hsel    = 1'b0;
      haddr   = 32'h0;
      htrans  = 2'h0;
      hwrite  = 1'b0;
      hsize   = 3'h2;
      hwdata  = 32'h0;
      din0    = 1'b0;
      din1    = 1'b0;
      clr     = 1'b0;
      tick(5);
      hresetn <= 1'b1;
      tick(1);
      t_reset();
      bus(1'b1, `DCPWM_IDX_CFG, 32'h0005_0101);
      bus(1'b1, `DCPWM_IDX_CH0_PERIOD, 32'h0000_0064);
      t_fwd();
      t_back();
      t_gate();
      t_ext();
      t_par();
      end_sim();
   end
endmodule
